// [pkg/qgp_pkg.sv]
// Package with register map, reset values and mode codes of the quad GPIO port
package qgp_pkg;
  localparam int          PIN_COUNT     = 4;
  localparam logic [15:0] DATA_ADDR     = 16'hFFDD;
  localparam logic [15:0] DIR_ADDR      = 16'hFFED;
  localparam logic [15:0] LCD_CTRL_ADDR = 16'hFFF0;
  localparam logic [31:0] DATA_BYTE     = 32'h0003FF74;
  localparam logic [31:0] DIR_BYTE      = 32'h0003FFB4;
  localparam logic [31:0] LCD_CTRL_BYTE = 32'h0003FFC0;
  localparam logic [7:0]  DATA_RST      = 8'hF0;
  localparam logic [7:0]  DIR_RST       = 8'hF0;
  localparam logic [3:0]  SGS_GPIO      = 4'h0;
  localparam logic [3:0]  SGS_RST       = 4'h0;
  localparam logic [3:0]  UPPER_ONES    = 4'hF;
  localparam logic [31:0] ALL_ONES      = 32'hFFFFFFFF;
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;
  // Operating modes, binary codes; 6 and 7 behave as active
  localparam logic [2:0]  MODE_ACTIVE   = 3'h0;
  localparam logic [2:0]  MODE_SUBACT   = 3'h1;
  localparam logic [2:0]  MODE_SLEEP    = 3'h2;
  localparam logic [2:0]  MODE_SUBSLEEP = 3'h3;
  localparam logic [2:0]  MODE_WATCH    = 3'h4;
  localparam logic [2:0]  MODE_STANDBY  = 3'h5;
  typedef enum logic [2:0] {
    QGP_RUN  = 3'b001,
    QGP_HOLD = 3'b010,
    QGP_OFF  = 3'b100
  } qgp_state_e;
endpackage : qgp_pkg

// [verilog/qgp_port.sv]
// Quad GPIO port shared with LCD common outputs, APB register access
// Overview of operation
// - Four bidirectional pins, data in bits 3..0
// - Output pin reads back latched data
// - Input pin reads back live level
// - Direction bit 1 drives, 0 inputs
// - Settings act only in GPIO assignment
// - Data register resets to F0
// - Direction register resets to F0
// - Direction register reads all ones
// - Nonzero segment select gives LCD commons
// - Reset and standby float the pins
// - Sleep, subsleep, watch freeze the pins
// - Active modes work normally
// - Segment select is control bits 3..0
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module qgp_port (
  input  wire logic        CLOCK,         // 50 MHz system clock
  input  wire logic        SYS_RST,       // Synchronous reset, active high
  input  wire logic [31:0] PADDR,         // APB address
  input  wire logic        PSEL,          // APB select
  input  wire logic        PENABLE,       // APB enable
  input  wire logic        PWRITE,        // APB direction
  input  wire logic [31:0] PWDATA,        // APB write data
  output logic      [31:0] PRDATA,        // APB read data
  output logic             PREADY,        // APB ready
  output logic             PSLVERR,       // APB error
  input  wire logic [2:0]  OP_MODE,       // Chip operating mode
  input  wire logic [3:0]  LCD_COM,       // LCD common drive levels 4..1
  input  wire logic [3:0]  GPIO_PINS_I,   // Pin levels
  output logic      [3:0]  GPIO_PINS_O,   // Pin drive levels
  output logic      [3:0]  GPIO_PINS_OE   // Pin drive enables
);
  logic [3:0]             data_r;
  logic [3:0]             dir_r;
  logic [3:0]             sgs_r;
  qgp_pkg::qgp_state_e    state_r;
  qgp_pkg::qgp_state_e    state_nxt;
  logic [3:0]             pin_o_nxt;
  logic [3:0]             pin_oe_nxt;
  logic [3:0]             rd_gpio;
  logic [31:0]            rd_nxt;

  // Address decode for the access phase
  wire acc      = PSEL & PENABLE & ~PREADY;
  wire hit_data = PADDR == qgp_pkg::DATA_BYTE;
  wire hit_dir  = PADDR == qgp_pkg::DIR_BYTE;
  wire hit_lcdc = PADDR == qgp_pkg::LCD_CTRL_BYTE;
  wire mapped   = hit_data | hit_dir | hit_lcdc;
  // Writes land only at the edge that completes the transfer (PREADY high)
  wire wr_en    = PSEL & PENABLE & PREADY & PWRITE;
  wire gpio_sel = sgs_r == qgp_pkg::SGS_GPIO;

  // Read mux per pin: latch when output, live pin when input
  genvar g;
  generate
    for (g = 0; g < qgp_pkg::PIN_COUNT; g++) begin : g_rd
      assign rd_gpio[g] = dir_r[g] ? data_r[g] : GPIO_PINS_I[g];
    end
  endgenerate

  assign rd_nxt = hit_data ? {24'h000000, qgp_pkg::UPPER_ONES, rd_gpio} :
                  hit_dir  ? qgp_pkg::ALL_ONES :
                  hit_lcdc ? {28'h0000000, sgs_r} : qgp_pkg::ZERO_WORD;

  // Mode decode: standby floats, low-power modes freeze
  always_comb begin
    case (OP_MODE)
      qgp_pkg::MODE_ACTIVE, qgp_pkg::MODE_SUBACT:   state_nxt = qgp_pkg::QGP_RUN;
      qgp_pkg::MODE_SLEEP, qgp_pkg::MODE_SUBSLEEP,
      qgp_pkg::MODE_WATCH:                          state_nxt = qgp_pkg::QGP_HOLD;
      qgp_pkg::MODE_STANDBY:                        state_nxt = qgp_pkg::QGP_OFF;
      default:                                      state_nxt = qgp_pkg::QGP_RUN;
    endcase
  end

  // Pin drive; LCD use overrides direction, hold keeps last drive
  always_comb begin
    pin_o_nxt  = GPIO_PINS_O;
    pin_oe_nxt = GPIO_PINS_OE;
    case (state_nxt)
      qgp_pkg::QGP_RUN: begin
        if (gpio_sel) begin
          pin_o_nxt  = data_r;
          pin_oe_nxt = dir_r;
        end else begin
          pin_o_nxt  = LCD_COM;
          pin_oe_nxt = 4'hF;
        end
      end
      qgp_pkg::QGP_HOLD: begin
        pin_o_nxt  = GPIO_PINS_O;
        pin_oe_nxt = GPIO_PINS_OE;
      end
      qgp_pkg::QGP_OFF: begin
        pin_o_nxt  = 4'h0;
        pin_oe_nxt = 4'h0;
      end
      default: begin
        pin_o_nxt  = 4'h0;
        pin_oe_nxt = 4'h0;
      end
    endcase
  end

  // Registers; upper bits are not stored so writes to them vanish
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      data_r <= qgp_pkg::DATA_RST[3:0];
      dir_r  <= qgp_pkg::DIR_RST[3:0];
      sgs_r  <= qgp_pkg::SGS_RST;
    end else if (wr_en) begin
      if (hit_data) data_r <= PWDATA[3:0];
      if (hit_dir)  dir_r  <= PWDATA[3:0];
      if (hit_lcdc) sgs_r  <= PWDATA[3:0];
    end
  end

  // Pins and mode state
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_r      <= qgp_pkg::QGP_OFF;
      GPIO_PINS_O  <= 4'h0;
      GPIO_PINS_OE <= 4'h0;
    end else begin
      state_r      <= state_nxt;
      GPIO_PINS_O  <= pin_o_nxt;
      GPIO_PINS_OE <= pin_oe_nxt;
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= qgp_pkg::ZERO_WORD;
    end else begin
      PREADY  <= acc;
      PSLVERR <= acc & ~mapped;
      PRDATA  <= (acc & ~PWRITE) ? rd_nxt : qgp_pkg::ZERO_WORD;
    end
  end

  // Pin state checks; pins lag their cause by one cycle
  a_reset_float: assert property (@(posedge CLOCK) $past(SYS_RST)
    |-> GPIO_PINS_OE == 4'h0)
    else $error("pins driven after reset");
  a_standby_float: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    state_r == qgp_pkg::QGP_OFF |-> GPIO_PINS_OE == 4'h0)
    else $error("pins driven in standby");
  a_hold_frozen: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    state_r == qgp_pkg::QGP_HOLD |-> $stable(GPIO_PINS_OE) && $stable(GPIO_PINS_O))
    else $error("pins changed in hold mode");
  a_lcd_drive: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    state_r == qgp_pkg::QGP_RUN && $past(state_nxt == qgp_pkg::QGP_RUN && !gpio_sel)
    |-> GPIO_PINS_OE == 4'hF && GPIO_PINS_O == $past(LCD_COM))
    else $error("lcd commons not driven");
  a_gpio_drive: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $past(state_nxt == qgp_pkg::QGP_RUN && gpio_sel)
    |-> GPIO_PINS_OE == $past(dir_r) && GPIO_PINS_O == $past(data_r))
    else $error("gpio drive mismatch");

  // Register reset values, seen right after reset
  a_reset_values: assert property (@(posedge CLOCK) $past(SYS_RST)
    |-> data_r == qgp_pkg::DATA_RST[3:0] && dir_r == qgp_pkg::DIR_RST[3:0])
    else $error("register reset value wrong");

  // Read path checks
  a_dir_reads_ones: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    PREADY && $past(hit_dir && !PWRITE) |-> PRDATA == qgp_pkg::ALL_ONES)
    else $error("direction register readable");
  a_data_readback: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    PREADY && $past(hit_data && !PWRITE)
    |-> PRDATA[7:0] == {qgp_pkg::UPPER_ONES, $past(rd_gpio)})
    else $error("data readback wrong");
  a_latch_read: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $past(acc && hit_data && !PWRITE && dir_r == 4'hF)
    |-> PRDATA[3:0] == $past(data_r))
    else $error("output pin read not from latch");
  a_live_read: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $past(acc && hit_data && !PWRITE && dir_r == 4'h0)
    |-> PRDATA[3:0] == $past(GPIO_PINS_I))
    else $error("input pin read not from pad");

  // Write path checks; nothing but a completed write moves a register
  a_data_write: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    wr_en && hit_data |=> data_r == $past(PWDATA[3:0]))
    else $error("data latch not updated");
  a_data_quiet: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !$past(wr_en && hit_data) |-> $stable(data_r))
    else $error("data latch moved without write");
  a_dir_quiet: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !$past(wr_en && hit_dir) |-> $stable(dir_r))
    else $error("direction moved without write");
  a_sel_field: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    wr_en && hit_lcdc |=> sgs_r == $past(PWDATA[3:0]))
    else $error("segment select not updated");
  a_ready_one: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    acc |=> PREADY ##1 !PREADY)
    else $error("ready not single pulse");

  // Main scenarios worth seeing at least once
  c_lcd_mode: cover property (@(posedge CLOCK) !gpio_sel && GPIO_PINS_OE == 4'hF);
  c_gpio_out: cover property (@(posedge CLOCK) gpio_sel && GPIO_PINS_OE != 4'h0);
  c_hold: cover property (@(posedge CLOCK) state_r == qgp_pkg::QGP_HOLD);
  c_dir_read: cover property (@(posedge CLOCK) PREADY && PRDATA == qgp_pkg::ALL_ONES);
endmodule // qgp_port

// [testbench/qgp_pins.sv]
// Board-side pad model for the quad GPIO port
`timescale 1ns/10ps
module qgp_pins (
  input  wire logic [3:0] pin_o,   // Port drive level
  input  wire logic [3:0] pin_oe,  // Port drive enable
  input  wire logic [3:0] ext_v,   // Board drive level
  output logic      [3:0] pin_lvl  // Resolved pad level
);
  // Port wins where it drives, board elsewhere, so no pad floats
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_v);
endmodule // qgp_pins

// [testbench/testbench.sv]
// Self-checking bench for the quad GPIO port
`timescale 1ns/10ps
module testbench;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [2:0]  mode = 0;
  logic [3:0]  com = 0, ext = 0, pin_lvl, pin_o, pin_oe, d, dr;
  int          miscompares = 0, comparisons = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  qgp_port dut_u (.CLOCK(clk), .SYS_RST(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OP_MODE(mode), .LCD_COM(com), .GPIO_PINS_I(pin_lvl), .GPIO_PINS_O(pin_o),
    .GPIO_PINS_OE(pin_oe));
  qgp_pins pins_u (.pin_o(pin_o), .pin_oe(pin_oe), .ext_v(ext), .pin_lvl(pin_lvl));
  // One APB transfer; the edge gap up front keeps psel from being set twice in one step
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, wd};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1 && ++n < 50);
    if (n >= 50) miscompares++;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Outputs read the latch, inputs the live pad
  function automatic logic [31:0] rd_exp(input logic [3:0] dv, input logic [3:0] dir,
                                         input logic [3:0] lvl);
    return {24'h000000, 4'hF, (dir & dv) | (~dir & lvl)};
  endfunction
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hD8228340));
    repeat (6) @(posedge clk);
    chk(pin_oe, 4'h0);
    rst <= 1'h0;
    ext <= 4'($urandom);
    apb(qgp_pkg::DIR_BYTE, 1'h0, 32'h0);
    chk(r, qgp_pkg::ALL_ONES);
    chk(pin_oe, 4'h0);
    apb(qgp_pkg::DATA_BYTE, 1'h0, 32'h0);
    chk(r, rd_exp(4'h0, 4'h0, ext));
    apb(qgp_pkg::DIR_BYTE, 1'h1, 32'hF);
    apb(qgp_pkg::DATA_BYTE, 1'h0, 32'h0);
    chk(r, 32'hF0);
    for (int i = 0; i < 24; i++) begin
      d = 4'($urandom);
      dr = 4'($urandom);
      mode <= 3'($urandom % 2);
      ext <= 4'($urandom);
      com <= 4'($urandom);
      apb(qgp_pkg::DATA_BYTE, 1'h1, {28'($urandom), d});
      apb(qgp_pkg::DIR_BYTE, 1'h1, {28'($urandom), dr});
      apb(qgp_pkg::DATA_BYTE, 1'h0, 32'h0);
      chk(r, rd_exp(d, dr, ext));
      chk(pin_oe, dr);
      chk(pin_o & dr, d & dr);
      // Segment select handover, then a frozen pad set, then standby
      apb(qgp_pkg::LCD_CTRL_BYTE, 1'h1, {28'h0, 4'(i % 15 + 1)});
      repeat (2) @(posedge clk);
      chk(pin_oe, 4'hF);
      chk(pin_o, com);
      mode <= 3'(2 + i % 3);
      @(posedge clk);
      apb(qgp_pkg::LCD_CTRL_BYTE, 1'h1, 32'h0);
      chk(pin_oe, 4'hF);
      chk(pin_o, com);
      mode <= qgp_pkg::MODE_STANDBY;
      repeat (2) @(posedge clk);
      chk(pin_oe, 4'h0);
    end
    apb(32'h00000100, 1'h0, 32'h0);
    chk(r, 32'h0);
    chk(e, 32'h1);
    wrap_up();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule // testbench
